// File: rtl/adccal_corrector.sv
// Purpose: offset subtraction, gain multiply, unity divide and clipping
// Assumes: one result per valid pulse, registered output
// Notes: state is a single packed struct
`timescale 1ns/1ps
`include "adccal_defs.svh"
module adccal_corrector
  import adccal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [23:0] in_data,
  input wire logic ofs_enable,
  input wire logic gain_enable,
  input wire logic [23:0] ofs_value,
  input wire logic [15:0] gain_value,
  output logic out_valid,
  output logic [23:0] out_data
);
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } adccal_corr_state_t;

  adccal_corr_state_t st;
  adccal_corr_state_t next_st;
  logic signed [24:0] diff;
  logic signed [41:0] prod;
  logic signed [41:0] scaled;

  // subtract offset, scale by gain over 8000h, then saturate
  always_comb begin
    next_st = st;
    diff = $signed({in_data[23], in_data});
    if (ofs_enable) begin
      diff = $signed({in_data[23], in_data}) - $signed({ofs_value[23], ofs_value});
    end
    // gain word is unsigned magnitude: 8000h unity, 7FFFh just under unity, FFFFh near two
    prod = 42'(diff) * $signed({26'h0, gain_value});
    scaled = prod >>> `ADCCAL_UNITY_SHIFT;
    if (!gain_enable) begin
      scaled = 42'(diff);
    end
    next_st.valid = in_valid;
    if (in_valid) begin
      if (scaled > 42'sh007FFFFF) begin
        next_st.data = `ADCCAL_POS_FULL;
      end else if (scaled < -42'sh00800000) begin
        next_st.data = `ADCCAL_NEG_FULL;
      end else begin
        next_st.data = scaled[23:0];
      end
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.valid;
  assign out_data = st.data;
endmodule

// File: rtl/adccal_defs.svh
// Purpose: constants for the calibration and mode control block
// Assumes: included by the corrector and top design files
// Notes: definitions only
`ifndef ADCCAL_DEFS_SVH
`define ADCCAL_DEFS_SVH
// register indices on the register port
`define ADCCAL_ADDR_CONFIG 8'h01
`define ADCCAL_ADDR_OFS_LOW 8'h02
`define ADCCAL_ADDR_OFS_MID 8'h03
`define ADCCAL_ADDR_OFS_HIGH 8'h04
`define ADCCAL_ADDR_GAIN_LOW 8'h05
`define ADCCAL_ADDR_GAIN_HIGH 8'h06
// configuration fields
`define ADCCAL_CFG_OFS_EN_BIT 5
`define ADCCAL_CFG_GAIN_EN_BIT 4
// reset values
`define ADCCAL_CONFIG_RESET 8'h00
`define ADCCAL_OFS_RESET 24'h000000
`define ADCCAL_GAIN_RESET 16'h8000
// arithmetic
`define ADCCAL_UNITY_SHIFT 15
`define ADCCAL_POS_FULL 24'h7FFFFF
`define ADCCAL_NEG_FULL 24'h800000
// timing counts in master clock periods and output data periods
`define ADCCAL_MODE_DELAY_CLK 3
`define ADCCAL_FIRST_SAMPLE_CLK 4
`define ADCCAL_SETTLE_WIDE 84
`define ADCCAL_SETTLE_LL_32 5
`define ADCCAL_SETTLE_LL_128 3
`define ADCCAL_SETTLE_LL_512 2
`define ADCCAL_SETTLE_LL_2048 2
`endif

// File: rtl/adccal_pkg.sv
// Purpose: types for the calibration and mode control block
// Assumes: adccal_defs.svh sits alongside
// Notes: types only; numbers live in the header
package adccal_pkg;
  // hardware mode pins as seen by the block
  typedef struct packed {
    logic resolution_select_pin;
    logic format_pin;
    logic frame_role_pin;
    logic [1:0] filter_pins;
    logic [1:0] osr_pins;
  } adccal_mode_t;

  // one result handed to the serial side
  typedef struct packed {
    logic [23:0] data;
    logic input_range_flag;
  } adccal_result_t;

  typedef enum logic [2:0] {
    ADCCAL_IDLE = 3'b001,
    ADCCAL_WAIT = 3'b010,
    ADCCAL_SETTLE = 3'b100
  } adccal_state_t;

  typedef enum logic [1:0] {
    ADCCAL_IF_SPI = 2'h0,
    ADCCAL_IF_FS_SLAVE = 2'h1,
    ADCCAL_IF_FS_MASTER = 2'h2
  } adccal_if_t;
endpackage

// File: rtl/adccal_top.sv
// Purpose: calibration datapath and hardware mode control of a converter back end
// Assumes: clk is the master clock; filter results arrive on clk; the serial
//   shifter runs on link_clk and takes results across a toggle handshake
// Notes: registers reached over a simple byte register port
// Function
// - out-of-range bit set to 1 in result status when input exceeds full scale
// - out-of-range flag comes straight from comparator, not through filter delay
// - offset and gain correction available only in SPI interface mode
// - offset correction applied only while configuration bit 5 is one
// - gain correction applied only while configuration bit 4 is one
// - holds 24-bit offset value and 16-bit gain value
// - result is (filter output minus offset) times gain divided by 8000h
// - corrected product is clipped to 24 bits before output
// - offset is two's complement; zero means no correction
// - offset bytes low, mid, high at 02h, 03h, 04h
// - gain bytes low, high at 05h, 06h
// - gain 8000h is unity, 7FFFh about two, 0000h zero; the code reads 7FFFh as just under unity
// - resolution pin one selects high resolution, zero low power
// - mode pins watched continuously; any change resets the conversion path
// - SPI mode first modulator sample 3.5 to 4.5 clocks after mode change
// - SPI data ready held high after mode change until settled, 84 periods
// - frame-sync outputs driven low after mode change until settled data
// - frame-sync mode change precedes next frame-sync edge by 5 or 1 clocks
// - interface pin zero selects SPI; else role pin zero slave, one master
// - low-latency filter settles in 5, 3, 2, 2 pulses for each ratio
`timescale 1ns/1ps
`include "adccal_defs.svh"
module adccal_top
  import adccal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire adccal_mode_t mode_pins,
  input wire logic reset_powerdown_n,
  input wire logic over_range_cmp,
  input wire logic filter_valid,
  input wire logic [23:0] filter_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic frame_sync,
  output logic [7:0] reg_rdata,
  output logic high_res_mode,
  output logic modulator_run,
  output logic filter_reset,
  output logic data_ready_n,
  output logic [23:0] out_data,
  output logic out_range,
  output logic [1:0] if_mode,
  output logic [23:0] link_data,
  output logic link_range
);
  // ****************************************************************
  // master clock state
  // ****************************************************************
  typedef struct packed {
    adccal_mode_t mode_s1;
    adccal_mode_t mode_s2;
    adccal_mode_t mode_prev;
    logic rstpin_s1;
    logic rstpin_s2;
    logic armed;
    logic [1:0] arm_cnt;
    logic [7:0] config_reg;
    logic [23:0] ofs;
    logic [15:0] gain;
    adccal_state_t fsm;
    logic [2:0] wait_cnt;
    logic [6:0] settle_cnt;
    logic settled;
    logic range_sticky;
    logic [7:0] rdata;
    logic high_res;
    logic run;
    logic flt_rst;
    logic data_ready_n_n;
    logic [23:0] data;
    logic range;
    logic [1:0] ifm;
    logic tog;
  } adccal_main_t;

  adccal_main_t st;
  adccal_main_t next_st;
  logic corr_valid;
  logic [23:0] corr_data;
  logic spi_mode;
  logic [6:0] settle_need;

  // ****************************************************************
  // interface decode
  // ****************************************************************
  // SPI whenever the format pin is low; the role pin only counts in frame-sync
  assign spi_mode = !st.mode_s2.format_pin;

  // ****************************************************************
  // settling length
  // ****************************************************************
  // settling length: wideband 84 periods, low latency per ratio
  always_comb begin
    settle_need = 7'(`ADCCAL_SETTLE_WIDE);
    if (st.mode_s2.filter_pins == 2'h2) begin
      case (st.mode_s2.osr_pins)
        2'h0: settle_need = 7'(`ADCCAL_SETTLE_LL_32);
        2'h1: settle_need = 7'(`ADCCAL_SETTLE_LL_128);
        2'h2: settle_need = 7'(`ADCCAL_SETTLE_LL_512);
        default: settle_need = 7'(`ADCCAL_SETTLE_LL_2048);
      endcase
    end
  end

  // ****************************************************************
  // correction datapath
  // ****************************************************************
  // correction datapath, off entirely outside SPI mode
  adccal_corrector u_corr (
    .clk(clk),
    .rst(rst),
    .in_valid(filter_valid),
    .in_data(filter_data),
    .ofs_enable(spi_mode && st.config_reg[`ADCCAL_CFG_OFS_EN_BIT]),
    .gain_enable(spi_mode && st.config_reg[`ADCCAL_CFG_GAIN_EN_BIT]),
    .ofs_value(st.ofs),
    .gain_value(st.gain),
    .out_valid(corr_valid),
    .out_data(corr_data)
  );

  // ****************************************************************
  // master next-state logic
  // ****************************************************************
  // next-state logic of the master domain
  always_comb begin
    next_st = st;
    // ************************************************************
    // pin synchronisers and mode decode
    // ************************************************************
    // two-stage synchronisers for pins
    next_st.mode_s1 = mode_pins;
    next_st.mode_s2 = st.mode_s1;
    next_st.rstpin_s1 = reset_powerdown_n;
    next_st.rstpin_s2 = st.rstpin_s1;
    next_st.mode_prev = st.mode_s2;
    // compare only once mode_prev holds a synced value, so startup pins are no change
    if (!st.armed) begin
      next_st.arm_cnt = st.arm_cnt + 2'h1;
      next_st.armed = (st.arm_cnt == 2'h2);
    end
    next_st.high_res = st.mode_s2.resolution_select_pin;
    if (!st.mode_s2.format_pin) begin
      next_st.ifm = ADCCAL_IF_SPI;
    end else if (st.mode_s2.frame_role_pin) begin
      next_st.ifm = ADCCAL_IF_FS_MASTER;
    end else begin
      next_st.ifm = ADCCAL_IF_FS_SLAVE;
    end

    // ************************************************************
    // register port
    // ************************************************************
    // register port writes; correction bytes only writable in SPI mode
    // configuration stays writable in every mode; only correction bytes are gated
    if (reg_wr) begin
      case (reg_addr)
        `ADCCAL_ADDR_CONFIG: next_st.config_reg = reg_wdata;
        `ADCCAL_ADDR_OFS_LOW: if (spi_mode) next_st.ofs[7:0] = reg_wdata;
        `ADCCAL_ADDR_OFS_MID: if (spi_mode) next_st.ofs[15:8] = reg_wdata;
        `ADCCAL_ADDR_OFS_HIGH: if (spi_mode) next_st.ofs[23:16] = reg_wdata;
        `ADCCAL_ADDR_GAIN_LOW: if (spi_mode) next_st.gain[7:0] = reg_wdata;
        `ADCCAL_ADDR_GAIN_HIGH: if (spi_mode) next_st.gain[15:8] = reg_wdata;
        default: next_st.config_reg = st.config_reg;
      endcase
    end
    // register port reads; unmapped reads return zero
    if (reg_rd) begin
      case (reg_addr)
        `ADCCAL_ADDR_CONFIG: next_st.rdata = st.config_reg;
        `ADCCAL_ADDR_OFS_LOW: next_st.rdata = st.ofs[7:0];
        `ADCCAL_ADDR_OFS_MID: next_st.rdata = st.ofs[15:8];
        `ADCCAL_ADDR_OFS_HIGH: next_st.rdata = st.ofs[23:16];
        `ADCCAL_ADDR_GAIN_LOW: next_st.rdata = st.gain[7:0];
        `ADCCAL_ADDR_GAIN_HIGH: next_st.rdata = st.gain[15:8];
        default: next_st.rdata = 8'h00;
      endcase
    end

    // ************************************************************
    // out-of-range flag
    // ************************************************************
    // comparator event flags the conversion in progress at once
    if (over_range_cmp) begin
      next_st.range_sticky = 1'b1;
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    // mode sequencer: restart on pin change or reset pin
    case (st.fsm)
      ADCCAL_IDLE: begin
        next_st.fsm = ADCCAL_WAIT;
        next_st.wait_cnt = 3'h0;
        next_st.flt_rst = 1'b1;
        next_st.run = 1'b0;
      end
      ADCCAL_WAIT: begin
        // mode takes effect then first sample after about four clocks
        next_st.wait_cnt = st.wait_cnt + 3'h1;
        if (st.wait_cnt == 3'(`ADCCAL_FIRST_SAMPLE_CLK - 1)) begin
          next_st.fsm = ADCCAL_SETTLE;
          next_st.flt_rst = 1'b0;
          next_st.run = 1'b1;
          next_st.settle_cnt = 7'h00;
        end
      end
      ADCCAL_SETTLE: begin
        if (corr_valid && !st.settled) begin
          next_st.settle_cnt = st.settle_cnt + 7'h01;
          if (st.settle_cnt + 7'h01 >= settle_need) begin
            next_st.settled = 1'b1;
          end
        end
      end
      default: next_st.fsm = ADCCAL_IDLE;
    endcase

    // ************************************************************
    // result delivery
    // ************************************************************
    // deliver a result; data ready pulses low for one clock per result
    // frame-sync modes keep data ready high; the link carries the word instead
    next_st.data_ready_n_n = 1'b1;
    if (corr_valid && st.fsm == ADCCAL_SETTLE && st.settled) begin
      next_st.data = corr_data;
      next_st.range = st.range_sticky || over_range_cmp;
      next_st.range_sticky = 1'b0;
      next_st.tog = !st.tog;
      next_st.data_ready_n_n = !spi_mode;
    end

    // ************************************************************
    // restart
    // ************************************************************
    // placed last so a restart overrides the sequencer and delivery of this cycle
    if ((st.armed && st.mode_s2 != st.mode_prev) || !st.rstpin_s2) begin
      next_st.fsm = ADCCAL_IDLE;
      next_st.settled = 1'b0;
      next_st.run = 1'b0;
      next_st.flt_rst = 1'b1;
      next_st.data_ready_n_n = 1'b1;
      next_st.data = 24'h000000;
      next_st.range = 1'b0;
      next_st.range_sticky = 1'b0;
      next_st.tog = !st.tog;
    end
  end

  // ****************************************************************
  // master state register
  // ****************************************************************
  // register master state
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      // reset pin stages idle high so leaving reset is not a false restart
      st.rstpin_s1 <= 1'b1;
      st.rstpin_s2 <= 1'b1;
      st.config_reg <= `ADCCAL_CONFIG_RESET;
      st.ofs <= `ADCCAL_OFS_RESET;
      st.gain <= `ADCCAL_GAIN_RESET;
      st.fsm <= ADCCAL_IDLE;
      st.data_ready_n_n <= 1'b1;
      st.flt_rst <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // master outputs, straight from the state register
  // ****************************************************************
  assign reg_rdata = st.rdata;
  assign high_res_mode = st.high_res;
  assign modulator_run = st.run;
  assign filter_reset = st.flt_rst;
  assign data_ready_n = st.data_ready_n_n;
  assign out_data = st.data;
  assign out_range = st.range;
  assign if_mode = st.ifm;

  // ****************************************************************
  // link clock side: frame-sync output word
  // ****************************************************************
  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic pending;
    logic [23:0] data;
    logic range;
  } adccal_link_t;

  adccal_link_t lk;
  adccal_link_t next_lk;

  // toggle crossing; word held stable in master domain while toggle settles
  // a toggle seen outside the load window waits as pending, so no result is lost
  // limitation: results must come further apart than the crossing plus one frame gap
  always_comb begin
    next_lk = lk;
    next_lk.t1 = st.tog;
    next_lk.t2 = lk.t1;
    next_lk.t3 = lk.t2;
    if (lk.t2 != lk.t3) begin
      next_lk.pending = 1'b1;
    end
    if ((lk.pending || lk.t2 != lk.t3) && frame_sync) begin
      next_lk.data = st.data;
      next_lk.range = st.range;
      next_lk.pending = 1'b0;
    end
  end

  // ****************************************************************
  // link state register
  // ****************************************************************
  // register link state
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  assign link_data = lk.data;
  assign link_range = lk.range;
endmodule

// File: testbench/adccal_host_model.sv
// Purpose: host at the frame-sync link
// Assumes: link_clk made by the bench
// Notes: frame_sync high five link clocks of eight, word taken at frame end
`timescale 1ns/1ps
module adccal_host_model (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic [23:0] link_data,
  input wire logic link_range,
  output logic frame_sync,
  output logic [24:0] word
);
  logic [2:0] cnt;
  // frame counter and capture
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cnt <= 3'h0;
      frame_sync <= 1'b0;
      word <= 25'h0;
    end else begin
      cnt <= cnt + 3'h1;
      frame_sync <= (cnt < 3'h5);
      if (cnt == 3'h7) begin
        word <= {link_range, link_data};
      end
    end
  end
endmodule

// File: testbench/adccal_monitor.sv
// Purpose: port checker for adccal_top
// Assumes: all checks on clk
// Notes: bound from the bench top
`timescale 1ns/1ps
module adccal_monitor
  import adccal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire adccal_mode_t mode_pins,
  input wire logic filter_valid,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic high_res_mode,
  input wire logic filter_reset,
  input wire logic data_ready_n,
  input wire logic [23:0] out_data,
  input wire logic [1:0] if_mode
);
  // ****************
  // sequences
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // pins unchanged long enough to be synced
  sequence pins_steady;
    $stable(mode_pins) [*8];
  endsequence
  // conversion path held in restart
  sequence path_cleared;
    filter_reset && data_ready_n && out_data == 24'h000000;
  endsequence
  // ****************
  // properties
  // ****************
  rst_hold_a: assert property (disable iff (1'b0) rst |=> data_ready_n && filter_reset)
    else $error("reset state wrong");
  data_ready_n_pulse_a: assert property (!data_ready_n |=> data_ready_n)
    else $error("ready longer than one cycle");
  data_ready_n_cause_a: assert property ($fell(data_ready_n) |-> $past(filter_valid, 2))
    else $error("ready without result");
  hold_off_a: assert property (filter_reset |-> data_ready_n)
    else $error("ready while filter held");
  mode_restart_a: assert property ($changed(mode_pins) |-> ##[2:8] path_cleared)
    else $error("no restart on pin change");
  if_sel_a: assert property (pins_steady |-> if_mode == (mode_pins.format_pin ?
    {mode_pins.frame_role_pin, !mode_pins.frame_role_pin} : 2'h0))
    else $error("interface mode wrong");
  res_sel_a: assert property (pins_steady |-> high_res_mode == mode_pins.resolution_select_pin)
    else $error("resolution mode wrong");
  unmapped_rd_a: assert property (reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h06)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// File: testbench/adccal_tb_top.sv
// Purpose: self-checking bench for adccal_top
// Assumes: host model on the link, registers driven here
// Notes: expected results come from a queue model
`timescale 1ns/1ps
module adccal_tb_top
  import adccal_pkg::*;
;
  logic clk, rst, link_clk, cmp, fv, wr, rd, fs, hr, frst, data_ready_n_n, rng, lrng, pwdn_n, run;
  adccal_mode_t pins, p;
  logic [23:0] fd, od, ld, o;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] ifm;
  logic [24:0] word, last;
  logic [7:0] regs [8];
  logic [15:0] gtab [4] = '{16'h8000, 16'h7FFF, 16'h0000, 16'h4321};
  logic [24:0] expq [$];
  int miscompares, total_checks, seed;
  // ****************
  // instances
  // ****************
  adccal_top i_adccal_top (.clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(rst),
    .mode_pins(pins), .reset_powerdown_n(pwdn_n), .over_range_cmp(cmp), .filter_valid(fv),
    .filter_data(fd), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .frame_sync(fs), .reg_rdata(rdata), .high_res_mode(hr), .modulator_run(run),
    .filter_reset(frst), .data_ready_n(data_ready_n_n), .out_data(od), .out_range(rng),
    .if_mode(ifm), .link_data(ld), .link_range(lrng));
  adccal_host_model i_adccal_host_model (.link_clk(link_clk), .link_rst(rst),
    .link_data(ld), .link_range(lrng), .frame_sync(fs), .word(word));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [23:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return r[23:0];
  endfunction
  // corrected result from the register copies
  function automatic logic [23:0] model(input logic [23:0] d);
    longint v;
    longint g;
    v = longint'($signed(d));
    g = longint'({regs[6], regs[5]});
    if (regs[1][5]) v = v - longint'($signed({regs[4], regs[3], regs[2]}));
    if (regs[1][4]) v = (v * g) >>> 15;
    if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
    if (v < -64'sh800000) v = -64'sh800000;
    return v[23:0];
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    if (a == 8'h01 || (a > 8'h01 && a < 8'h07 && !pins.format_pin)) regs[a[2:0]] = d;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk({17'h0, rdata}, {17'h0, regs[a[2:0]]});
  endtask
  task automatic send(input logic [23:0] d, input bit keep, input bit over);
    @(negedge clk);
    fv = 1'b1;
    fd = d;
    cmp = over;
    if (keep) last = {over, model(d)};
    if (keep) expq.push_back(last);
    @(negedge clk);
    fv = 1'b0;
    cmp = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic settle(input int n);
    repeat (16) @(negedge clk);
    repeat (n) send(rnd(), 1'b0, 1'b0);
  endtask
  task automatic setpins(input adccal_mode_t q);
    @(negedge clk);
    pins = q;
    repeat (12) @(negedge clk);
  endtask
  // ****************
  // clocks and checks
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // link clock, unrelated phase
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // each ready pulse takes the oldest expected result
  always @(negedge clk) begin
    if (data_ready_n_n === 1'b0) begin
      if (expq.size() == 0) chk(25'h1, 25'h0);
      else chk({rng, od}, expq.pop_front());
    end
  end
  // watchdog
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 2;
    {rst, fv, cmp, wr, rd, pwdn_n} = 6'b100001;
    {fd, addr, wdata} = 40'h0;
    pins = 7'b1001011;
    foreach (regs[i]) regs[i] = 8'h00;
    regs[6] = 8'h80;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    settle(2);
    for (int a = 0; a < 8; a++) rd_reg(8'(a));
    for (int i = 0; i < 8; i++) begin
      o = i[0] ? 24'h800000 : rnd();
      wr_reg(8'h02, o[7:0]);
      wr_reg(8'h03, o[15:8]);
      wr_reg(8'h04, o[23:16]);
      wr_reg(8'h05, gtab[i[2:1]][7:0]);
      wr_reg(8'h06, gtab[i[2:1]][15:8]);
      wr_reg(8'h01, {2'b00, i[1:0], 4'h0});
      for (int a = 1; a < 7; a++) rd_reg(8'(a));
      send(rnd(), 1'b1, i[0]);
      send(24'h7FFFFF, 1'b1, 1'b0);
      send(24'h800000, 1'b1, !i[0]);
    end
    repeat (30) @(negedge clk);
    chk(word, last);
    chk(25'(expq.size()), 25'h0);
    p = pins;
    p.filter_pins = 2'b00;
    setpins(p);
    chk({data_ready_n_n, od}, 25'h1000000);
    settle(84);
    send(rnd(), 1'b1, 1'b0);
    repeat (4) @(negedge clk);
    chk(25'(expq.size()), 25'h0);
    // pin change, then a reset pin pulse three clocks later; path restarts and resettles
    p = pins;
    p.filter_pins = 2'b10;
    p.osr_pins = 2'b00;
    @(negedge clk);
    pins = p;
    repeat (3) @(negedge clk);
    pwdn_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({23'h0, run, frst}, 25'h1);
    pwdn_n = 1'b1;
    settle(5);
    chk({24'h0, run}, 25'h1);
    send(rnd(), 1'b1, 1'b1);
    repeat (4) @(negedge clk);
    chk(25'(expq.size()), 25'h0);
    for (int j = 0; j < 4; j++) begin
      p = pins;
      p.format_pin = j[1];
      p.frame_role_pin = j[0];
      p.resolution_select_pin = j[0];
      setpins(p);
      chk({23'h0, ifm}, {23'h0, j[1] ? {j[0], !j[0]} : 2'b00});
      chk({24'h0, hr}, {24'h0, j[0]});
      if (j[1]) begin
        repeat (20) @(negedge clk);
        chk({1'b0, ld}, 25'h0);
        o = rnd();
        wr_reg(8'h06, o[7:0]);
        rd_reg(8'h06);
      end
    end
    tally_and_finish();
  end
endmodule
bind adccal_top adccal_monitor i_mon (.clk(clk), .rst(rst), .mode_pins(mode_pins),
  .filter_valid(filter_valid), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .high_res_mode(high_res_mode), .filter_reset(filter_reset), .data_ready_n(data_ready_n),
  .out_data(out_data), .if_mode(if_mode));
